//--- src/amac_consts.vh
`ifndef AMAC_CONSTS_VH
`define AMAC_CONSTS_VH
// Operation codes carried with each access
`define AMAC_OP_READ   2'h0
`define AMAC_OP_WRITE  2'h1
`define AMAC_OP_DELETE 2'h2
`define AMAC_OP_EXEC   2'h3
// Memory types
`define AMAC_MEM_ROM   2'h0
`define AMAC_MEM_RAM   2'h1
`define AMAC_MEM_FLASH 2'h2
// Permission word layout: 4 ops for privilege mode (low), 4 for user mode (high)
`define AMAC_PERM_W    8
`define AMAC_USER_OFS  4
// Manufacturing defaults per area: privilege all ops, user read and execute only
`define AMAC_DEF_PERM  8'h9F
`define AMAC_DEF_BASE  16'h0000
`define AMAC_DEF_LIMIT 16'hFFFF
// Attribute port select codes
`define AMAC_SEL_PERM  2'h0
`define AMAC_SEL_BASE  2'h1
`define AMAC_SEL_LIMIT 2'h2
`define AMAC_SEL_MEM   2'h3
`define AMAC_DEF_MEM   2'h0
`endif

//--- src/amac_area_match.v
`timescale 1ns/1ps
`default_nettype none
// Finds the lowest-numbered area whose memory type and address window hold an address
module amac_area_match #(
  parameter AREAS = 4,
  parameter AW    = 16,
  parameter IW    = 2
) (
  input  wire [AREAS*AW-1:0] base_flat,
  input  wire [AREAS*AW-1:0] limit_flat,
  input  wire [AREAS*2-1:0]  mem_flat,
  input  wire [1:0]          mem,
  input  wire [AW-1:0]       addr,
  output reg                 hit,
  output reg  [IW-1:0]       idx
);
  integer i;
  // Scan from the top so the lowest matching area wins
  always @* begin
    hit = 1'b0;
    idx = {IW{1'b0}};
    for (i = AREAS-1; i >= 0; i = i - 1) begin
      if (mem_flat[i*2 +: 2] == mem && addr >= base_flat[i*AW +: AW] &&
          addr <= limit_flat[i*AW +: AW]) begin
        hit = 1'b1;
        idx = i[IW-1:0];
      end
    end
  end
endmodule // amac_area_match
`default_nettype wire

//--- src/amac_top.v
`include "amac_consts.vh"
`timescale 1ns/1ps
`default_nettype none
// Overview of the unit
// The core presents one access per cycle: the target memory type and address,
// the operation, the mode of the issuing code and the place that code runs from.
// Two area matchers turn both addresses into area indices. The permission words
// of those two areas are then looked up: the target area must allow the operation
// for the mode, and the source area must allow execution for the mode.
// The result is registered, so every access is answered one cycle after it is
// taken, with either a forwarded access toward the memories or a refusal flag.
// A refused access never drives the memory side, so nothing it asked for can be
// observed or changed by the requesting code.
// Area attributes live in flip-flops. After reset they are filled with the
// manufacturing defaults, one area per cycle; until that walk is over no access
// and no attribute request is taken, so nothing runs under stale attributes.
// The attribute port is open to privilege-mode requesters only for writes;
// reads are answered for either mode, which lets software confirm its set-up.
// Limitation: the lowest-numbered matching area wins when windows overlap, so
// software must order overlapping areas from the most specific to the widest.
module amac_top #(
  parameter AREAS = 4,
  parameter AW    = 16,
  parameter IW    = 2
) (
  input  wire            ref_clk,
  input  wire            reset,
  // Core access request
  input  wire            req_valid,
  input  wire            req_priv,
  input  wire [1:0]      req_op,
  input  wire [1:0]      req_mem,
  input  wire [AW-1:0]   req_addr,
  input  wire [1:0]      fetch_mem,
  input  wire [AW-1:0]   fetch_addr,
  input  wire [15:0]     req_wdata,
  // Forwarded access toward memories
  output reg             mem_valid,
  output reg  [1:0]      mem_op,
  output reg  [1:0]      mem_sel,
  output reg  [AW-1:0]   mem_addr,
  output reg  [15:0]     mem_wdata,
  output reg             acc_done,
  output reg             acc_denied,
  output reg             init_done,
  // Attribute control port
  input  wire            cfg_wr,
  input  wire            cfg_rd,
  input  wire            cfg_priv,
  input  wire [IW-1:0]   cfg_area,
  input  wire [1:0]      cfg_sel,
  input  wire [AW-1:0]   cfg_wdata,
  output reg  [AW-1:0]   cfg_rdata,
  output reg             cfg_ack,
  output reg             cfg_rejected
);
  reg  [`AMAC_PERM_W-1:0] perm_r  [0:AREAS-1];
  reg  [AW-1:0]           base_r  [0:AREAS-1];
  reg  [AW-1:0]           limit_r [0:AREAS-1];
  reg  [1:0]              memt_r  [0:AREAS-1];
  reg  [IW:0]             init_cnt_r;
  wire [AREAS*AW-1:0]     base_flat;
  wire [AREAS*AW-1:0]     limit_flat;
  wire [AREAS*2-1:0]      mem_flat;
  wire                    src_hit;
  wire [IW-1:0]           src_idx;
  wire                    dst_hit;
  wire [IW-1:0]           dst_idx;
  reg                     grant;

  // Bit of a permission word for a given mode and operation
  // Used for both the target check and the source execute check, so the two
  // lookups can never disagree on the word layout
  function [2:0] perm_bit;
    input       priv;
    input [1:0] op;
    begin
      perm_bit = (priv ? 3'h0 : 3'd`AMAC_USER_OFS) + {1'b0, op};
    end
  endfunction

  // Flatten the attribute arrays so both matchers see the same copy
  genvar g;
  generate
    for (g = 0; g < AREAS; g = g + 1) begin : g_flat
      assign base_flat[g*AW +: AW]  = base_r[g];
      assign limit_flat[g*AW +: AW] = limit_r[g];
      assign mem_flat[g*2 +: 2]     = memt_r[g];
    end
  endgenerate

  // Area holding the code that issues the access, and the targeted area
  amac_area_match #(.AREAS(AREAS), .AW(AW), .IW(IW)) u_src (
    .base_flat  (base_flat),
    .limit_flat (limit_flat),
    .mem_flat   (mem_flat),
    .mem        (fetch_mem),
    .addr       (fetch_addr),
    .hit        (src_hit),
    .idx        (src_idx)
  );
  amac_area_match #(.AREAS(AREAS), .AW(AW), .IW(IW)) u_dst (
    .base_flat  (base_flat),
    .limit_flat (limit_flat),
    .mem_flat   (mem_flat),
    .mem        (req_mem),
    .addr       (req_addr),
    .hit        (dst_hit),
    .idx        (dst_idx)
  );

  // Target area must permit the operation and source area execution for the mode; unmapped addresses are refused
  // since there is no default grant path
  always @* begin
    grant = src_hit && dst_hit &&
            perm_r[dst_idx][perm_bit(req_priv, req_op)] &&
            perm_r[src_idx][perm_bit(req_priv, `AMAC_OP_EXEC)];
  end

  // Reset loads defaults one area per cycle; accesses held off until done
  // Trade-off: a walk of AREAS cycles costs a few cycles after reset but keeps
  // the attribute storage free of a wide parallel reset
  always @(posedge ref_clk) begin
    if (reset) begin
      init_cnt_r <= {(IW+1){1'b0}};
      init_done  <= 1'b0;
    end else if (!init_done) begin
      if (init_cnt_r == AREAS[IW:0] - 1'b1)
        init_done <= 1'b1;
      init_cnt_r <= init_cnt_r + 1'b1;
    end
  end

  // Attribute storage: defaults during init, then privileged writes only
  always @(posedge ref_clk) begin
    if (!init_done) begin
      perm_r[init_cnt_r[IW-1:0]]  <= `AMAC_DEF_PERM;
      base_r[init_cnt_r[IW-1:0]]  <= `AMAC_DEF_BASE;
      limit_r[init_cnt_r[IW-1:0]] <= `AMAC_DEF_LIMIT;
      memt_r[init_cnt_r[IW-1:0]]  <= `AMAC_DEF_MEM;
    end else if (cfg_wr && cfg_priv) begin
      case (cfg_sel)
        `AMAC_SEL_PERM:  perm_r[cfg_area]  <= cfg_wdata[`AMAC_PERM_W-1:0];
        `AMAC_SEL_BASE:  base_r[cfg_area]  <= cfg_wdata;
        `AMAC_SEL_LIMIT: limit_r[cfg_area] <= cfg_wdata;
        default:         memt_r[cfg_area]  <= cfg_wdata[1:0];
      endcase
    end
  end

  // Control port answers one cycle later; user-mode writes flagged, not applied
  // The read data holds its last value between reads, so a slow reader may
  // sample it late without losing it
  always @(posedge ref_clk) begin
    if (reset) begin
      cfg_rdata    <= {AW{1'b0}};
      cfg_ack      <= 1'b0;
      cfg_rejected <= 1'b0;
    end else begin
      cfg_ack      <= init_done && (cfg_wr || cfg_rd);
      cfg_rejected <= init_done && cfg_wr && !cfg_priv;
      if (init_done && cfg_rd) begin
        case (cfg_sel)
          `AMAC_SEL_PERM:  cfg_rdata <= {{(AW-`AMAC_PERM_W){1'b0}}, perm_r[cfg_area]};
          `AMAC_SEL_BASE:  cfg_rdata <= base_r[cfg_area];
          `AMAC_SEL_LIMIT: cfg_rdata <= limit_r[cfg_area];
          default:         cfg_rdata <= {{(AW-2){1'b0}}, memt_r[cfg_area]};
        endcase
      end
    end
  end

  // Forward only granted accesses; a denied one never reaches memory
  // Operation, select and address keep the last granted values; only the
  // write data is cleared, since it is the one field that carries content
  always @(posedge ref_clk) begin
    if (reset) begin
      mem_valid  <= 1'b0;
      mem_op     <= `AMAC_OP_READ;
      mem_sel    <= `AMAC_MEM_ROM;
      mem_addr   <= {AW{1'b0}};
      mem_wdata  <= 16'h0000;
      acc_done   <= 1'b0;
      acc_denied <= 1'b0;
    end else begin
      mem_valid  <= req_valid && init_done && grant;
      acc_done   <= req_valid && init_done;
      acc_denied <= req_valid && init_done && !grant;
      if (req_valid && init_done && grant) begin
        mem_op    <= req_op;
        mem_sel   <= req_mem;
        mem_addr  <= req_addr;
        mem_wdata <= req_wdata;
      end else begin
        mem_wdata <= 16'h0000; // no stale data left on the bus
      end
    end
  end
endmodule // amac_top
`default_nettype wire

//--- verif/amac_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module amac_checker #(parameter AW = 16) (
  input wire logic          ref_clk,
  input wire logic          reset,
  input wire logic          req_valid,
  input wire logic [1:0]    req_op,
  input wire logic [AW-1:0] req_addr,
  input wire logic          mem_valid,
  input wire logic [1:0]    mem_op,
  input wire logic [AW-1:0] mem_addr,
  input wire logic          acc_done,
  input wire logic          acc_denied,
  input wire logic          init_done,
  input wire logic          cfg_wr,
  input wire logic          cfg_rd,
  input wire logic          cfg_priv,
  input wire logic          cfg_ack,
  input wire logic          cfg_rejected
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Defaults must be loaded before any access can slip through
  sequence s_loading; !init_done [*2]; endsequence
  property p_init; $fell(reset) |-> s_loading ##[1:4] init_done; endproperty
  a_init: assert property (p_init) else $error("init_done late");
  property p_kind; acc_done |-> (mem_valid ^ acc_denied); endproperty
  a_kind: assert property (p_kind) else $error("outcome not unique");
  property p_answer; req_valid && init_done |=> acc_done; endproperty
  a_answer: assert property (p_answer) else $error("access unchecked");
  // Nothing may reach memory without a taken request
  property p_quiet; !(req_valid && init_done) |=> !acc_done && !mem_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("spurious access");
  property p_fields; mem_valid |-> mem_addr == $past(req_addr) && mem_op == $past(req_op);
  endproperty
  a_fields: assert property (p_fields) else $error("forwarded fields wrong");
  property p_ack; (cfg_wr || cfg_rd) && init_done |=> cfg_ack; endproperty
  a_ack: assert property (p_ack) else $error("no cfg_ack");
  property p_rej; cfg_wr && !cfg_priv && init_done |=> cfg_rejected; endproperty
  a_rej: assert property (p_rej) else $error("user write not rejected");
  property p_rej_src; cfg_rejected |-> $past(cfg_wr) && !$past(cfg_priv); endproperty
  a_rej_src: assert property (p_rej_src) else $error("rejected wrongly");
endmodule // amac_checker
bind amac_top amac_checker #(.AW(AW)) amac_checker_inst (.*);
`default_nettype wire

//--- verif/amac_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// Core side: issues mode-tagged accesses and attribute requests
module amac_core_model (
  input  wire logic       ref_clk,
  output var  logic       req_valid, req_priv, cfg_wr, cfg_rd, cfg_priv,
  output var  logic [1:0] req_op, req_mem, fetch_mem, cfg_area, cfg_sel,
  output var  logic [15:0] req_addr, fetch_addr, req_wdata, cfg_wdata
);
  // Idle values before the first request
  initial begin
    {req_valid, req_priv, cfg_wr, cfg_rd, cfg_priv, req_op, req_mem} = '0;
    {fetch_mem, cfg_area, cfg_sel, req_addr, fetch_addr, req_wdata, cfg_wdata} = '0;
  end
  // Released data is inverted so stale values never pass by luck
  task automatic acc(input logic p, input logic [1:0] o, m, input logic [15:0] a, fa);
    @(posedge ref_clk);
    {req_valid, req_priv, req_op, req_mem, req_addr, fetch_addr} <= {1'b1, p, o, m, a, fa};
    {fetch_mem, req_wdata} <= {2'h0, a ^ 16'h5A5A};
    @(posedge ref_clk);
    {req_valid, req_addr, req_wdata} <= {1'b0, ~a, ~req_wdata};
  endtask
  // Attribute write or read, one cycle wide
  task automatic cfg(input logic w, p, input logic [1:0] ar, s, input logic [15:0] d);
    @(posedge ref_clk);
    {cfg_wr, cfg_rd, cfg_priv, cfg_area, cfg_sel, cfg_wdata} <= {w, !w, p, ar, s, d};
    @(posedge ref_clk);
    {cfg_wr, cfg_rd, cfg_wdata} <= {2'b00, ~d};
  endtask
endmodule // amac_core_model
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "amac_consts.vh"
module tb_top;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  wire logic req_valid, req_priv, cfg_wr, cfg_rd, cfg_priv, mem_valid, acc_done, acc_denied;
  wire logic init_done, cfg_ack, cfg_rejected;
  wire logic [1:0] req_op, req_mem, fetch_mem, cfg_area, cfg_sel, mem_op, mem_sel;
  wire logic [15:0] req_addr, fetch_addr, req_wdata, cfg_wdata, mem_addr, mem_wdata, cfg_rdata;
  int failures = 0;
  int num_checks = 0;
  int lfsr = 32'h2D05;
  int attr[4][4];
  amac_top amac_top_inst (.*);
  amac_core_model amac_core_model_inst (.*);
  always #12.5 ref_clk = ~ref_clk;
  task automatic check(string what, logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    if (failures == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Lowest-numbered area holding the address wins, -1 when none does
  function automatic int find(int m, int a);
    for (int i = 0; i < 4; i++) if (attr[i][3] == m && attr[i][1] <= a && a <= attr[i][2]) return i;
    return -1;
  endfunction
  task automatic acc(logic p, logic [1:0] o, m, logic [15:0] a, fa);
    int t, s, g;
    amac_core_model_inst.acc(p, o, m, a, fa);
    #1;
    t = find(m, a);
    s = find(0, fa);
    g = t >= 0 && s >= 0 && attr[t][0][p ? o : 4 + o] && attr[s][0][p ? 3 : 7];
    check("acc_done", acc_done, 1);
    check("mem_valid", mem_valid, g);
    check("acc_denied", acc_denied, !g);
    check("mem_wdata", mem_wdata, g ? a ^ 16'h5A5A : 16'h0000);
    if (g) begin
      check("mem_sel", mem_sel, m);
      check("mem_addr", mem_addr, a);
    end
  endtask
  // Next state of the stimulus shift register
  function automatic int lfsr_next(int v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic cfgw(logic p, logic [19:0] e);
    amac_core_model_inst.cfg(1'b1, p, e[19:18], e[17:16], e[15:0]);
    #1;
    check("cfg_rejected", cfg_rejected, !p);
    if (p) attr[e[19:18]][e[17:16]] = e[15:0];
    amac_core_model_inst.cfg(1'b0, 1'b1, e[19:18], e[17:16], 16'h0000);
    #1;
    check("cfg_rdata", cfg_rdata, attr[e[19:18]][e[17:16]]);
  endtask
  // Main sequence: early request, defaults, set-up, random traffic
  initial begin
    for (int i = 0; i < 4; i++) attr[i] = '{`AMAC_DEF_PERM, `AMAC_DEF_BASE, `AMAC_DEF_LIMIT, 0};
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    amac_core_model_inst.acc(1'b1, 2'h0, 2'h0, 16'h0010, 16'h0100);
    #1;
    check("early acc_done", acc_done, 0);
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < 16; i++) cfgw(1'b0, {i[3:0], 16'hA5C3});
    for (int i = 0; i < 8; i++) acc(i[2], i[1:0], 2'h0, 16'h0040, 16'h0100);
    cfgw(1'b1, 20'h27FFF);
    cfgw(1'b1, 20'h70001);
    cfgw(1'b1, 20'h4003F);
    cfgw(1'b1, 20'hB0002);
    cfgw(1'b1, 20'h8005F);
    cfgw(1'b1, 20'hD8000);
    cfgw(1'b1, 20'hC001F);
    for (int i = 0; i < 300; i++) begin
      lfsr = lfsr_next(lfsr);
      acc(lfsr[0], lfsr[2:1], lfsr[4:3] == 2'h3 ? 2'h1 : lfsr[4:3], lfsr[20:5],
          {lfsr[31], lfsr[14:0]});
    end
    test_done();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #200000;
    failures++;
    test_done();
  end
endmodule // tb_top
`default_nettype wire
